// file: rtl/opc_pkg.sv
// opc_pkg: register map, field layout, reset values and codes of the oscillator and
// power control bank; assumes a 32-bit apb slave with one byte register per word
package opc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_FREQ_TRIM = 8'h18;
    localparam logic [7:0] OFF_OSC_ENABLE = 8'h19;
    localparam logic [7:0] OFF_GATE_BOOST = 8'h1a;
    localparam logic [7:0] OFF_REF_LEVEL = 8'h1b;
    localparam logic [7:0] OFF_AMP_CURRENT = 8'h1c;
    localparam logic [7:0] OFF_PUMP1_CLOCK = 8'h1d;
    localparam logic [7:0] OFF_PUMP2_CLOCK = 8'h1e;
    localparam logic [7:0] OFF_PUMP_POWER = 8'h1f;
    // write masks: reserved positions keep zero
    localparam logic [7:0] MASK_FREQ_TRIM = 8'hff;
    localparam logic [7:0] MASK_OSC_ENABLE = 8'h01;
    localparam logic [7:0] MASK_GATE_BOOST = 8'h07;
    localparam logic [7:0] MASK_REF_LEVEL = 8'h3f;
    localparam logic [7:0] MASK_AMP_CURRENT = 8'h07;
    localparam logic [7:0] MASK_PUMP_CLOCK = 8'h77;
    localparam logic [7:0] MASK_PUMP_POWER = 8'hdf;
    // reset values
    localparam logic [7:0] RST_FREQ_TRIM = 8'h44;
    localparam logic [7:0] RST_OSC_ENABLE = 8'h00;
    localparam logic [7:0] RST_GATE_BOOST = 8'h00;
    localparam logic [7:0] RST_REF_LEVEL = 8'h00;
    localparam logic [7:0] RST_AMP_CURRENT = 8'h00;
    localparam logic [7:0] RST_PUMP_CLOCK = 8'h00;
    localparam logic [7:0] RST_PUMP_POWER = 8'h08;
    // field positions
    localparam int unsigned POS_NORMAL_TRIM = 0;
    localparam int unsigned POS_IDLE_TRIM = 4;
    localparam int unsigned POS_NORMAL_FS = 0;
    localparam int unsigned POS_IDLE_FS = 4;
    localparam int unsigned POS_STANDBY = 0;
    localparam int unsigned POS_TRIPLE = 1;
    localparam int unsigned POS_CAP_MODE = 2;
    localparam int unsigned POS_PUMP1_STOP = 3;
    localparam int unsigned POS_PUMP2_RUN = 4;
    localparam int unsigned POS_NEG_COM = 6;
    localparam int unsigned POS_PWROFF_MON = 7;
    // codes
    localparam logic [1:0] IFSEL_RGB_BIT = 2'b10;
    localparam logic [2:0] BOOST_INHIBIT_TRI = 3'h0;
    localparam logic [2:0] AMP_OFF = 3'h0;
    localparam logic [2:0] AMP_INHIBIT = 3'h7;
    localparam logic [5:0] REF_FIRST_STOP = 6'h33;
    localparam logic [5:0] REF_EXTERNAL = 6'h3f;
    // nominal oscillator frequency in kHz, the base of the trim percentages per code
    localparam int unsigned NOMINAL_KHZ = 2630;
    // pump clock multiples in quarters of line frequency: 1/4 .. 8
    localparam int unsigned PUMP_QUARTERS_W = 6;

    typedef enum logic [2:0] {
        OPC_IDLE = 3'b001,
        OPC_ACCESS = 3'b010,
        OPC_DONE = 3'b100
    } opc_bus_state_t;

    typedef struct packed {
        logic [7:0] freq_trim;
        logic [7:0] osc_enable;
        logic [7:0] gate_boost;
        logic [7:0] ref_level;
        logic [7:0] amp_current;
        logic [7:0] pump1_clock;
        logic [7:0] pump2_clock;
        logic [7:0] pump_power;
    } opc_regs_t;

    typedef struct packed {
        logic osc_on;
        logic [3:0] trim_code;
        logic [7:0] trim_percent;
        logic [2:0] gate_boost_factor;
        logic ref_internal_on;
        logic [5:0] ref_level_sel;
        logic amp_on;
        logic [2:0] amp_current_sel;
        logic [PUMP_QUARTERS_W-1:0] pump1_quarters;
        logic [PUMP_QUARTERS_W-1:0] pump23_quarters;
        logic pump1_on;
        logic pump2_on;
        logic triple_pump;
        logic standby;
        logic negative_com_en;
        logic poweroff_monitor;
        logic setting_error;
    } opc_ctrl_t;
endpackage

// file: rtl/opc_decode.sv
// opc_decode: turns stored register fields into control levels for the analog side
// assumes its register inputs come straight from flip-flops of the bank
`timescale 1ns/1ps
`default_nettype none
module opc_decode (
    input wire opc_pkg::opc_regs_t i_regs,
    input wire logic [1:0] i_interface_sel,
    input wire logic i_idle_mode,
    output var opc_pkg::opc_ctrl_t o_ctrl
);
    function automatic logic [7:0] trim_pct(input logic [3:0] code);
        case (code)
            4'h0: trim_pct = 8'h32;
            4'h1: trim_pct = 8'h43;
            4'h2: trim_pct = 8'h4b;
            4'h3: trim_pct = 8'h53;
            4'h4: trim_pct = 8'h64;
            4'h5: trim_pct = 8'h6c;
            4'h6: trim_pct = 8'h75;
            4'h7: trim_pct = 8'h7d;
            4'h8: trim_pct = 8'h64;
            4'h9: trim_pct = 8'h85;
            4'ha: trim_pct = 8'h96;
            4'hb: trim_pct = 8'ha7;
            4'hc: trim_pct = 8'hc8;
            4'hd: trim_pct = 8'hd9;
            4'he: trim_pct = 8'he9;
            default: trim_pct = 8'hfa;
        endcase
    endfunction

    function automatic logic [opc_pkg::PUMP_QUARTERS_W-1:0] pump_q(input logic [2:0] code);
        case (code)
            3'h0: pump_q = 6'h01;
            3'h1: pump_q = 6'h02;
            3'h2: pump_q = 6'h04;
            3'h3: pump_q = 6'h06;
            3'h4: pump_q = 6'h08;
            3'h5: pump_q = 6'h0c;
            3'h6: pump_q = 6'h10;
            default: pump_q = 6'h20;
        endcase
    endfunction

    logic standby;
    logic [3:0] trim;
    logic [2:0] fs1;
    logic [2:0] fs2;
    logic tri_sel;
    logic cap_mode;

    always_comb begin
        standby = i_regs.pump_power[opc_pkg::POS_STANDBY];
        tri_sel = i_regs.pump_power[opc_pkg::POS_TRIPLE];
        cap_mode = i_regs.pump_power[opc_pkg::POS_CAP_MODE];
        // idle modes take the idle trim and pump divider fields
        trim = i_idle_mode ? i_regs.freq_trim[opc_pkg::POS_IDLE_TRIM +: 4]
                           : i_regs.freq_trim[opc_pkg::POS_NORMAL_TRIM +: 4];
        fs1 = i_idle_mode ? i_regs.pump1_clock[opc_pkg::POS_IDLE_FS +: 3]
                          : i_regs.pump1_clock[opc_pkg::POS_NORMAL_FS +: 3];
        fs2 = i_idle_mode ? i_regs.pump2_clock[opc_pkg::POS_IDLE_FS +: 3]
                          : i_regs.pump2_clock[opc_pkg::POS_NORMAL_FS +: 3];
        o_ctrl.osc_on = i_regs.osc_enable[0] && !(i_interface_sel[1]) && !standby;
        o_ctrl.trim_code = trim;
        o_ctrl.trim_percent = trim_pct(trim);
        o_ctrl.gate_boost_factor = i_regs.gate_boost[2:0];
        o_ctrl.ref_level_sel = i_regs.ref_level[5:0];
        o_ctrl.ref_internal_on = (i_regs.ref_level[5:0] < opc_pkg::REF_FIRST_STOP) && !standby;
        o_ctrl.amp_current_sel = i_regs.amp_current[2:0];
        o_ctrl.amp_on = (i_regs.amp_current[2:0] != opc_pkg::AMP_OFF) && !standby;
        o_ctrl.pump1_quarters = pump_q(fs1);
        o_ctrl.pump23_quarters = pump_q(fs2);
        o_ctrl.pump2_on = i_regs.pump_power[opc_pkg::POS_PUMP2_RUN] && !standby;
        o_ctrl.pump1_on = !i_regs.pump_power[opc_pkg::POS_PUMP1_STOP] && !standby;
        o_ctrl.triple_pump = tri_sel && !cap_mode;
        o_ctrl.standby = standby;
        o_ctrl.negative_com_en = i_regs.pump_power[opc_pkg::POS_NEG_COM];
        o_ctrl.poweroff_monitor = i_regs.pump_power[opc_pkg::POS_PWROFF_MON];
        // inhibited combinations flagged for software; only triple with cap mode is overridden, triple_pump held low
        o_ctrl.setting_error = (tri_sel && cap_mode)
            || (tri_sel && i_regs.gate_boost[2:0] == opc_pkg::BOOST_INHIBIT_TRI)
            || (i_regs.amp_current[2:0] == opc_pkg::AMP_INHIBIT);
    end
endmodule // opc_decode
`default_nettype wire

// file: rtl/opc_regs.sv
// opc_regs: apb register bank for oscillator and charge pump control
// assumes an apb3 master on I_CLOCK; interface select and idle mode come from other blocks
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module opc_regs (
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [opc_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [1:0] I_INTERFACE_SEL,
    input wire logic I_IDLE_MODE,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output var opc_pkg::opc_ctrl_t O_CTRL
);
    typedef struct packed {
        opc_pkg::opc_regs_t regs;
        logic [31:0] rdata;
    } opc_state_t;

    logic [1:0] rst_sync;
    logic rst_n;
    opc_state_t st;
    opc_state_t next_st;
    logic access;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic allowed;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic opc_pkg::opc_regs_t reset_regs();
        opc_pkg::opc_regs_t r;
        r.freq_trim = opc_pkg::RST_FREQ_TRIM;
        r.osc_enable = opc_pkg::RST_OSC_ENABLE;
        r.gate_boost = opc_pkg::RST_GATE_BOOST;
        r.ref_level = opc_pkg::RST_REF_LEVEL;
        r.amp_current = opc_pkg::RST_AMP_CURRENT;
        r.pump1_clock = opc_pkg::RST_PUMP_CLOCK;
        r.pump2_clock = opc_pkg::RST_PUMP_CLOCK;
        r.pump_power = opc_pkg::RST_PUMP_POWER;
        return r;
    endfunction

    always_comb begin
        next_st = st;
        access = I_PSEL && I_PENABLE;
        wbyte = I_PWDATA[7:0];
        mapped = (I_PADDR[1:0] == 2'b00) && (I_PADDR[7:2] >= opc_pkg::OFF_FREQ_TRIM[5:0])
            && (I_PADDR[7:2] <= opc_pkg::OFF_PUMP_POWER[5:0]);
        // one register per word: byte address is four times the register index
        rbyte = 8'h00;
        case (I_PADDR[7:2])
            opc_pkg::OFF_FREQ_TRIM[5:0]: rbyte = st.regs.freq_trim;
            opc_pkg::OFF_OSC_ENABLE[5:0]: rbyte = st.regs.osc_enable;
            opc_pkg::OFF_GATE_BOOST[5:0]: rbyte = st.regs.gate_boost;
            opc_pkg::OFF_REF_LEVEL[5:0]: rbyte = st.regs.ref_level;
            opc_pkg::OFF_AMP_CURRENT[5:0]: rbyte = st.regs.amp_current;
            opc_pkg::OFF_PUMP1_CLOCK[5:0]: rbyte = st.regs.pump1_clock;
            opc_pkg::OFF_PUMP2_CLOCK[5:0]: rbyte = st.regs.pump2_clock;
            opc_pkg::OFF_PUMP_POWER[5:0]: rbyte = st.regs.pump_power;
            default: rbyte = 8'h00;
        endcase
        // in standby only the oscillator and power register accept writes
        allowed = !st.regs.pump_power[opc_pkg::POS_STANDBY]
            || I_PADDR[7:2] == opc_pkg::OFF_OSC_ENABLE[5:0]
            || I_PADDR[7:2] == opc_pkg::OFF_PUMP_POWER[5:0];
        // read data captured in setup so the access phase drives it from a flop
        next_st.rdata = 32'h00000000;
        if (I_PSEL && !I_PENABLE && !I_PWRITE && mapped) begin
            next_st.rdata = {24'h000000, rbyte};
        end
        if (access) begin
            if (I_PWRITE && mapped && allowed) begin
                case (I_PADDR[7:2])
                    opc_pkg::OFF_FREQ_TRIM[5:0]:
                        next_st.regs.freq_trim = wbyte & opc_pkg::MASK_FREQ_TRIM;
                    opc_pkg::OFF_OSC_ENABLE[5:0]:
                        next_st.regs.osc_enable = wbyte & opc_pkg::MASK_OSC_ENABLE;
                    opc_pkg::OFF_GATE_BOOST[5:0]:
                        next_st.regs.gate_boost = wbyte & opc_pkg::MASK_GATE_BOOST;
                    opc_pkg::OFF_REF_LEVEL[5:0]:
                        next_st.regs.ref_level = wbyte & opc_pkg::MASK_REF_LEVEL;
                    opc_pkg::OFF_AMP_CURRENT[5:0]:
                        next_st.regs.amp_current = wbyte & opc_pkg::MASK_AMP_CURRENT;
                    opc_pkg::OFF_PUMP1_CLOCK[5:0]:
                        next_st.regs.pump1_clock = wbyte & opc_pkg::MASK_PUMP_CLOCK;
                    opc_pkg::OFF_PUMP2_CLOCK[5:0]:
                        next_st.regs.pump2_clock = wbyte & opc_pkg::MASK_PUMP_CLOCK;
                    opc_pkg::OFF_PUMP_POWER[5:0]:
                        next_st.regs.pump_power = wbyte & opc_pkg::MASK_PUMP_POWER;
                    default: next_st.regs = st.regs;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            st.regs <= reset_regs();
            st.rdata <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    // zero wait state: read data was captured in the setup cycle
    assign O_PREADY = 1'b1;
    assign O_PRDATA = st.rdata;
    assign O_PSLVERR = I_PSEL && I_PENABLE && (!mapped || (I_PWRITE && !allowed));

    opc_decode u_decode (
        .i_regs(st.regs),
        .i_interface_sel(I_INTERFACE_SEL),
        .i_idle_mode(I_IDLE_MODE),
        .o_ctrl(O_CTRL)
    );

    property p_osc_follow;
        @(posedge I_CLOCK) disable iff (!rst_n)
        O_CTRL.osc_on == (st.regs.osc_enable[0] && !I_INTERFACE_SEL[1]
            && !st.regs.pump_power[0]);
    endproperty
    a_osc_follow: assert property (p_osc_follow) else $error("oscillator level wrong");

    property p_rgb_stop;
        @(posedge I_CLOCK) disable iff (!rst_n)
        I_INTERFACE_SEL[1] |-> !O_CTRL.osc_on;
    endproperty
    a_rgb_stop: assert property (p_rgb_stop) else $error("oscillator runs in rgb mode");

    property p_trim_sel;
        @(posedge I_CLOCK) disable iff (!rst_n)
        O_CTRL.trim_code == (I_IDLE_MODE ? st.regs.freq_trim[7:4] : st.regs.freq_trim[3:0]);
    endproperty
    a_trim_sel: assert property (p_trim_sel) else $error("wrong trim field used");

    property p_trim_nominal;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (O_CTRL.trim_code == 4'h8) |-> (O_CTRL.trim_percent == 8'h64);
    endproperty
    a_trim_nominal: assert property (p_trim_nominal) else $error("code 8 not nominal");

    property p_ref_stop;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (st.regs.ref_level[5:0] >= 6'h33) |-> !O_CTRL.ref_internal_on;
    endproperty
    a_ref_stop: assert property (p_ref_stop) else $error("reference not stopped");

    property p_pump1;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (!st.regs.pump_power[3] && !st.regs.pump_power[0]) |-> O_CTRL.pump1_on;
    endproperty
    a_pump1: assert property (p_pump1) else $error("pump one not running");

    property p_pump2_write;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h7c && I_PWDATA[4] && !I_PWDATA[0])
            |=> O_CTRL.pump2_on;
    endproperty
    a_pump2_write: assert property (p_pump2_write) else $error("pump two not on");

    property p_standby_hold;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (st.regs.pump_power[0] && I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h6c)
            |=> $stable(st.regs.ref_level);
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("write in standby");

    property p_reserved_zero;
        @(posedge I_CLOCK) disable iff (!rst_n)
        st.regs.osc_enable[7:1] == 7'h00 && st.regs.pump_power[5] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_inhibit_flag;
        @(posedge I_CLOCK) disable iff (!rst_n)
        (st.regs.pump_power[1] && st.regs.pump_power[2]) |-> O_CTRL.setting_error;
    endproperty
    a_inhibit_flag: assert property (p_inhibit_flag) else $error("inhibit not flagged");

    c_rgb: cover property (@(posedge I_CLOCK) disable iff (!rst_n) I_INTERFACE_SEL[1]);
    c_standby: cover property (@(posedge I_CLOCK) disable iff (!rst_n) O_CTRL.standby);
    c_idle: cover property (@(posedge I_CLOCK) disable iff (!rst_n) I_IDLE_MODE && O_CTRL.osc_on);
endmodule // opc_regs
`default_nettype wire

// file: verification/opc_host_model.sv
// opc_host_model: apb master standing in for the host controller of the register bank
// assumes one clock shared with the slave; every signal moves right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module opc_host_model (
    input wire logic i_clk,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // inhibited codes go out only when a test asks for them
    // no wait limit here: the bench timeout cuts a hung slave short
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule // opc_host_model
`default_nettype wire

// file: verification/opc_regs_tb.sv
// opc_regs_tb: self-checking bench for the oscillator and pump control register bank
// assumes opc_regs as top, reached over apb through opc_host_model on one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module opc_regs_tb;
    logic clk;
    logic nrst;
    logic [1:0] isel;
    logic idle;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    opc_pkg::opc_ctrl_t ctrl;
    logic [31:0] rd;
    logic err;
    logic [3:0] ex;
    logic [5:0] st;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    // reset values and writable bits per register, 0x60 upward
    logic [7:0] rst_v [8] = '{8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    logic [7:0] msk [8] = '{8'hff, 8'h01, 8'h07, 8'h3f, 8'h07, 8'h77, 8'h77, 8'hdf};
    logic [7:0] pct [16] = '{8'h32, 8'h43, 8'h4b, 8'h53, 8'h64, 8'h6c, 8'h75, 8'h7d,
                             8'h64, 8'h85, 8'h96, 8'ha7, 8'hc8, 8'hd9, 8'he9, 8'hfa};
    logic [5:0] qtr [8] = '{6'h01, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h20};
    logic [7:0] refc [5] = '{8'h00, 8'h32, 8'h33, 8'h3e, 8'h3f};
    logic [7:0] pwr [8] = '{8'h00, 8'h08, 8'h10, 8'h04, 8'h06, 8'h40, 8'h82, 8'h02};

    assign st = {ctrl.standby, ctrl.osc_on, ctrl.pump1_on, ctrl.pump2_on, ctrl.amp_on,
                 ctrl.ref_internal_on};

    opc_regs dut (.I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_INTERFACE_SEL(isel),
        .I_IDLE_MODE(idle), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_CTRL(ctrl));

    opc_host_model host (.i_clk(clk), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // about 400 cycles of traffic; the ceiling at 6000 leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            results();
        end
    end

    function automatic logic [7:0] ra(input int i);
        return 8'h60 + 8'(4 * i);
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // settles to the falling edge so decoded controls show the new value
    task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        host.xfer(1'b1, a, d, rd, err);
        check(32'(err), 32'(e));
        @(negedge clk);
    endtask

    task rdx(input logic [7:0] a, input logic [31:0] x, input logic e);
        host.xfer(1'b0, a, 32'h0, rd, err);
        check(32'(err), 32'(e));
        check(rd, x);
    endtask

    task mode(input logic [1:0] s, input logic i);
        @(posedge clk);
        isel <= s;
        idle <= i;
        @(negedge clk);
    endtask

    task tend(input string n);
        $display("test %s done, %0d mismatches so far", n, fails);
    endtask

    task results;
        $display("%0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        isel = 2'b00;
        idle = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) rdx(ra(i), 32'(rst_v[i]), 1'b0);
        check(32'({ctrl.osc_on, ctrl.pump1_on}), 32'h0);
        tend("reset");
        // pump_power last: its all-ones value enters standby
        for (int i = 0; i < 8; i++) begin
            wr(ra(i), 32'hffffffff, 1'b0);
            rdx(ra(i), 32'(msk[i]), 1'b0);
        end
        wr(ra(7), 32'h0, 1'b0);
        tend("masks");
        check(32'(ctrl.osc_on), 32'h1);
        wr(ra(1), 32'h0, 1'b0);
        check(32'(ctrl.osc_on), 32'h0);
        wr(ra(1), 32'h1, 1'b0);
        for (int s = 0; s < 4; s++) begin
            mode(2'(s), 1'b0);
            check(32'(ctrl.osc_on), 32'(s < 2));
        end
        mode(2'b00, 1'b0);
        tend("oscillator");
        for (int c = 0; c < 16; c++) begin
            wr(ra(0), 32'(c) | 32'((15 - c) << 4), 1'b0);
            check(32'(ctrl.trim_code), 32'(c));
            check(32'(ctrl.trim_percent), 32'(pct[c]));
            mode(2'b00, 1'b1);
            check(32'(ctrl.trim_percent), 32'(pct[15 - c]));
            mode(2'b00, 1'b0);
        end
        for (int c = 0; c < 8; c++) begin
            wr(ra(5), 32'(c) | 32'((7 - c) << 4), 1'b0);
            wr(ra(6), 32'(7 - c) | 32'(c << 4), 1'b0);
            check(32'(ctrl.pump1_quarters), 32'(qtr[c]));
            check(32'(ctrl.pump23_quarters), 32'(qtr[7 - c]));
            mode(2'b00, 1'b1);
            check(32'(ctrl.pump1_quarters), 32'(qtr[7 - c]));
            check(32'(ctrl.pump23_quarters), 32'(qtr[c]));
            mode(2'b00, 1'b0);
        end
        tend("clocks");
        foreach (refc[k]) begin
            wr(ra(3), 32'(refc[k]), 1'b0);
            check(32'(ctrl.ref_level_sel), 32'(refc[k]));
            check(32'(ctrl.ref_internal_on), 32'(refc[k] < 8'h33));
        end
        for (int c = 0; c < 8; c++) begin
            wr(ra(4), 32'(c), 1'b0);
            check(32'({ctrl.amp_current_sel, ctrl.amp_on, ctrl.setting_error}), 32'({3'(c), c != 0, c == 7}));
        end
        wr(ra(4), 32'h1, 1'b0);
        foreach (pwr[k]) begin
            wr(ra(7), 32'(pwr[k]), 1'b0);
            ex = {~pwr[k][3], pwr[k][4], pwr[k][1] & ~pwr[k][2], pwr[k][1] & pwr[k][2]};
            check(32'({ctrl.pump1_on, ctrl.pump2_on, ctrl.triple_pump, ctrl.setting_error}), 32'(ex));
            check(32'({ctrl.negative_com_en, ctrl.poweroff_monitor}), 32'({pwr[k][6], pwr[k][7]}));
        end
        // triple pumping is still selected here
        for (int c = 0; c < 8; c++) begin
            wr(ra(2), 32'(c), 1'b0);
            check(32'({ctrl.gate_boost_factor, ctrl.setting_error}), 32'({3'(c), c == 0}));
        end
        wr(ra(2), 32'h0, 1'b0);
        wr(ra(7), 32'h0, 1'b0);
        check(32'(ctrl.setting_error), 32'h0);
        wr(ra(2), 32'h1, 1'b0);
        tend("power");
        wr(ra(4), 32'h3, 1'b0);
        wr(ra(3), 32'h10, 1'b0);
        wr(ra(1), 32'h1, 1'b0);
        wr(ra(7), 32'h11, 1'b0);
        check(32'(st), 32'h20);
        wr(ra(2), 32'h5, 1'b1);
        wr(ra(3), 32'h20, 1'b1);
        rdx(ra(3), 32'h10, 1'b0);
        rdx(ra(2), 32'h1, 1'b0);
        wr(ra(1), 32'h0, 1'b0);
        rdx(ra(1), 32'h0, 1'b0);
        wr(ra(1), 32'h1, 1'b0);
        wr(ra(7), 32'h10, 1'b0);
        check(32'(st), 32'h1f);
        rdx(ra(4), 32'h3, 1'b0);
        tend("standby");
        wr(8'h5c, 32'h1, 1'b1);
        rdx(8'h5c, 32'h0, 1'b1);
        wr(8'h61, 32'h0, 1'b1);
        rdx(ra(0), 32'h0f, 1'b0);
        tend("refused");
        results();
    end
endmodule // opc_regs_tb
`default_nettype wire
